// ==== hw/ecp_dead_band.sv ====
// dead-band edge delay: holds an output low until its input has been high long enough
`timescale 1ns/10ps
module ecp_dead_band
    import ecp_pkg::*;
#(
    parameter int DLY_W = 7
) (
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic             ce_i,
    input  wire logic             in_i,
    input  wire logic [DLY_W-1:0] delay_i,
    output logic                  out_o
);
    localparam int CNT_W = DLY_W + 2;

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             out_reg;
    logic             out_next;
    logic [CNT_W-1:0] target;

    // delay counted in oscillator periods, four per step
    assign target = CNT_W'(delay_i) * CNT_W'(DEAD_STEP_OSC);

    // rising edge delayed, falling edge immediate, so two sides never overlap
    always_comb begin
        cnt_next = cnt_reg;
        out_next = out_reg;
        if (!in_i) begin
            cnt_next = '0;
            out_next = 1'b0;
        end else if (cnt_reg >= target) begin
            out_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_reg <= '0;
            out_reg <= 1'b0;
        end else if (ce_i) begin
            cnt_reg <= cnt_next;
            out_reg <= out_next;
        end
    end

    assign out_o = out_reg;
endmodule

// ==== hw/ecp_pkg.sv ====
// package: register map, field layout and timing constants of the capture/pwm steering unit
package ecp_pkg;
    // register byte offsets, one aligned word each
    localparam logic [7:0] OFS_UNIT1_CTRL  = 8'h00;
    localparam logic [7:0] OFS_UNIT2_CTRL  = 8'h04;
    localparam logic [7:0] OFS_UNIT3_CTRL  = 8'h08;
    localparam logic [7:0] OFS_UNIT4_CTRL  = 8'h0c;
    localparam logic [7:0] OFS_DUTY_LOW    = 8'h10;
    localparam logic [7:0] OFS_DUTY_HIGH   = 8'h14;
    localparam logic [7:0] OFS_TMR_CTRL    = 8'h18;
    localparam logic [7:0] OFS_TMR_GATE    = 8'h1c;
    localparam logic [7:0] OFS_TMR_LOW     = 8'h20;
    localparam logic [7:0] OFS_TMR_HIGH    = 8'h24;
    localparam logic [7:0] OFS_DEAD_BAND   = 8'h28;
    localparam logic [7:0] OFS_PERIOD      = 8'h2c;
    localparam logic [7:0] OFS_RELOC0      = 8'h30;
    localparam logic [7:0] OFS_RELOC1      = 8'h34;
    localparam logic [7:0] OFS_CAPT_LOW    = 8'h38;
    localparam logic [7:0] OFS_CAPT_HIGH   = 8'h3c;

    // field positions
    localparam int STEER_MSB   = 7;
    localparam int STEER_LSB   = 6;
    localparam int DUTY_LO_MSB = 5;
    localparam int DUTY_LO_LSB = 4;
    localparam int TMR_ON_BIT  = 0;
    localparam int TMR_EXT_BIT = 6;
    localparam int TMR_GE_BIT  = 7;
    localparam int GATE_POL_BIT = 6;
    localparam int RELOC_A_BIT = 0;
    localparam int RELOC_B_BIT = 1;
    localparam int RELOC_C_BIT = 2;
    localparam int RELOC_D_BIT = 3;

    // reset values
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] DATA_RST   = 8'h00;
    localparam logic [7:0] PERIOD_RST = 8'hff;

    // dead band is four oscillator periods per step
    localparam int DEAD_STEP_OSC = 4;

    // unit mode select code for capture on every rising edge, pwm code
    localparam logic [3:0] MODE_OFF     = 4'h0;
    localparam logic [3:0] MODE_CAPTURE = 4'h5;
    localparam logic [3:0] MODE_PWM_MSB = 4'hc;

    // steering codes
    typedef enum logic [1:0] {
        ECP_STEER_SINGLE = 2'b00,
        ECP_STEER_FWD    = 2'b01,
        ECP_STEER_HALF   = 2'b10,
        ECP_STEER_REV    = 2'b11
    } ecp_steer_e;

    // four bridge output pins, primary and alternate location
    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic d;
    } ecp_bridge_s;
endpackage

// ==== hw/ecp_top.sv ====
// capture/pwm unit with bridge output steering, capture time base and apb registers
`timescale 1ns/10ps
module ecp_top
    import ecp_pkg::*;
#(
    parameter int TMR_W    = 16,
    parameter int DUTY_W   = 10,
    parameter int PRESCALE = 1
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        ce_i,
    input  wire logic        sleep_i,
    input  wire logic        ext_clk_i,
    input  wire logic        gate_i,
    input  wire logic        capture_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output ecp_bridge_s      bridge_pri_o,
    output ecp_bridge_s      bridge_alt_o,
    output ecp_bridge_s      bridge_oe_pri_o,
    output ecp_bridge_s      bridge_oe_alt_o,
    output logic             capture_flag_o
);
    // elaboration check: byte lanes and the prescale counter are sized for these values only
    if (TMR_W != 16 || DUTY_W != 10 || PRESCALE < 1 || PRESCALE > 64) begin : g_bad_param
        $error("ecp_top: unsupported parameter values");
    end


    localparam int PS_W = 7;

    // control and data registers
    logic [7:0] ctrl_reg [4];
    logic [7:0] ctrl_next [4];
    logic [7:0] duty_reg;
    logic [7:0] duty_next;
    logic [7:0] dead_reg;
    logic [7:0] dead_next;
    logic [7:0] period_reg;
    logic [7:0] period_next;
    logic [7:0] tctrl_reg;
    logic [7:0] tctrl_next;
    logic [7:0] tgate_reg;
    logic [7:0] tgate_next;
    logic [7:0] reloc_reg;
    logic [7:0] reloc_next;
    logic [TMR_W-1:0] tmr_reg;
    logic [TMR_W-1:0] tmr_next;
    logic [TMR_W-1:0] capt_reg;
    logic [TMR_W-1:0] capt_next;
    logic             capf_reg;
    logic             capf_next;

    // synchronisers for pins
    logic [1:0] ext_sync_reg;
    logic [1:0] gate_sync_reg;
    logic [1:0] capt_sync_reg;
    logic       ext_prev_reg;
    logic       capt_prev_reg;

    // pwm state
    logic [7:0]        pcnt_reg;
    logic [7:0]        pcnt_next;
    logic [1:0]        pfrac_reg;
    logic [1:0]        pfrac_next;
    logic [PS_W-1:0]   ps_reg;
    logic [PS_W-1:0]   ps_next;
    logic [DUTY_W-1:0] dlat_reg;
    logic [DUTY_W-1:0] dlat_next;

    // apb decode: zero wait states, slverr on unmapped address
    logic wr_en;
    logic rd_hit;
    logic [7:0] rd_byte;

    // the unit mode and steering decode is used for unit 1 only
    function automatic logic is_pwm(input logic [7:0] c);
        return c[3:2] == MODE_PWM_MSB[3:2];
    endfunction

    function automatic logic is_capture(input logic [7:0] c);
        return c[3:0] == MODE_CAPTURE;
    endfunction

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ext_sync_reg  <= 2'b00;
            gate_sync_reg <= 2'b00;
            capt_sync_reg <= 2'b00;
            ext_prev_reg  <= 1'b0;
            capt_prev_reg <= 1'b0;
        end else if (ce_i) begin
            ext_sync_reg  <= {ext_sync_reg[0], ext_clk_i};
            gate_sync_reg <= {gate_sync_reg[0], gate_i};
            capt_sync_reg <= {capt_sync_reg[0], capture_i};
            ext_prev_reg  <= ext_sync_reg[1];
            capt_prev_reg <= capt_sync_reg[1];
        end
    end

    logic ext_rise;
    logic capt_rise;
    logic gate_true;
    logic tmr_tick;
    logic tmr_run;
    assign ext_rise  = ext_sync_reg[1] & ~ext_prev_reg;
    assign capt_rise = capt_sync_reg[1] & ~capt_prev_reg;
    assign gate_true = gate_sync_reg[1] ^ tgate_reg[GATE_POL_BIT];

    // external clock keeps ticking in sleep; instruction tick freezes there
    assign tmr_tick = tctrl_reg[TMR_EXT_BIT] ? ext_rise : ~sleep_i;
    assign tmr_run  = tctrl_reg[TMR_ON_BIT]
                    & (~tgate_reg[TMR_GE_BIT] | gate_true);

    assign wr_en  = psel_i & penable_i & pwrite_i;
    assign rd_hit = (paddr_i[1:0] == 2'b00) && (paddr_i <= OFS_CAPT_HIGH);

    // register writes, timer counting and capture
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ctrl_next[i] = ctrl_reg[i];
        end
        duty_next   = duty_reg;
        dead_next   = dead_reg;
        period_next = period_reg;
        tctrl_next  = tctrl_reg;
        tgate_next  = tgate_reg;
        reloc_next  = reloc_reg;
        tmr_next    = tmr_reg;
        capt_next   = capt_reg;
        capf_next   = capf_reg;
        if (tmr_run && tmr_tick) begin
            tmr_next = tmr_reg + TMR_W'(1);
        end
        // capture sampled in sleep too; with the instruction tick the count just stands
        if (is_capture(ctrl_reg[0]) && capt_rise) begin
            capt_next = tmr_reg;
        end
        if (wr_en) begin
            unique case (paddr_i)
                OFS_UNIT1_CTRL: ctrl_next[0] = pwdata_i[7:0];
                OFS_UNIT2_CTRL: ctrl_next[1] = pwdata_i[7:0];
                OFS_UNIT3_CTRL: ctrl_next[2] = {2'b00, pwdata_i[5:0]};
                OFS_UNIT4_CTRL: ctrl_next[3] = {2'b00, pwdata_i[5:0]};
                OFS_DUTY_LOW:   duty_next    = pwdata_i[7:0];
                OFS_TMR_CTRL:   tctrl_next   = pwdata_i[7:0];
                OFS_TMR_GATE:   tgate_next   = pwdata_i[7:0];
                OFS_TMR_LOW:    tmr_next     = {tmr_reg[15:8], pwdata_i[7:0]};
                OFS_TMR_HIGH:   tmr_next     = {pwdata_i[7:0], tmr_reg[7:0]};
                OFS_DEAD_BAND:  dead_next    = pwdata_i[7:0];
                OFS_PERIOD:     period_next  = pwdata_i[7:0];
                OFS_RELOC0:     reloc_next   = pwdata_i[7:0];
                OFS_CAPT_HIGH:  capf_next    = 1'b0;
                default: ;
            endcase
        end
        // a capture in the clearing cycle wins
        if (is_capture(ctrl_reg[0]) && capt_rise) begin
            capf_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < 4; i++) begin
                ctrl_reg[i] <= CTRL_RST;
            end
            duty_reg   <= DATA_RST;
            dead_reg   <= DATA_RST;
            period_reg <= PERIOD_RST;
            tctrl_reg  <= CTRL_RST;
            tgate_reg  <= CTRL_RST;
            reloc_reg  <= CTRL_RST;
            tmr_reg    <= '0;
            capt_reg   <= '0;
            capf_reg   <= 1'b0;
        end else if (ce_i) begin
            for (int i = 0; i < 4; i++) begin
                ctrl_reg[i] <= ctrl_next[i];
            end
            duty_reg   <= duty_next;
            dead_reg   <= dead_next;
            period_reg <= period_next;
            tctrl_reg  <= tctrl_next;
            tgate_reg  <= tgate_next;
            reloc_reg  <= reloc_next;
            tmr_reg    <= tmr_next;
            capt_reg   <= capt_next;
            capf_reg   <= capf_next;
        end
    end

    // read mux; reserved and write-only bits read zero
    always_comb begin
        rd_byte = 8'h00;
        unique case (paddr_i)
            OFS_UNIT1_CTRL: rd_byte = ctrl_reg[0];
            OFS_UNIT2_CTRL: rd_byte = ctrl_reg[1];
            OFS_UNIT3_CTRL: rd_byte = ctrl_reg[2];
            OFS_UNIT4_CTRL: rd_byte = ctrl_reg[3];
            OFS_DUTY_LOW:   rd_byte = duty_reg;
            OFS_DUTY_HIGH:  rd_byte = dlat_reg[9:2];
            OFS_TMR_CTRL:   rd_byte = tctrl_reg;
            OFS_TMR_GATE:   rd_byte = {tgate_reg[7:3], gate_sync_reg[1], tgate_reg[1:0]};
            OFS_TMR_LOW:    rd_byte = tmr_reg[7:0];
            OFS_TMR_HIGH:   rd_byte = tmr_reg[15:8];
            OFS_DEAD_BAND:  rd_byte = dead_reg;
            OFS_PERIOD:     rd_byte = period_reg;
            OFS_RELOC0:     rd_byte = reloc_reg;
            OFS_RELOC1:     rd_byte = {7'h00, capf_reg};
            OFS_CAPT_LOW:   rd_byte = capt_reg[7:0];
            OFS_CAPT_HIGH:  rd_byte = capt_reg[15:8];
            default:        rd_byte = 8'h00;
        endcase
    end

    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~rd_hit;
    assign prdata_o  = {24'h000000, rd_byte};

    // pwm time base: period counter with 2-bit fraction, one step per PRESCALE oscillator ticks
    logic [1:0] steer;
    logic       pwm_on;
    logic       mod;
    logic       period_end;
    assign steer  = ctrl_reg[0][STEER_MSB:STEER_LSB];
    assign pwm_on = is_pwm(ctrl_reg[0]);
    assign period_end = (pcnt_reg == period_reg) && (pfrac_reg == 2'b11)
                      && (ps_reg == PS_W'(PRESCALE - 1));

    always_comb begin
        ps_next    = ps_reg;
        pfrac_next = pfrac_reg;
        pcnt_next  = pcnt_reg;
        dlat_next  = dlat_reg;
        if (!pwm_on) begin
            ps_next    = '0;
            pfrac_next = 2'b00;
            pcnt_next  = 8'h00;
        end else if (ps_reg != PS_W'(PRESCALE - 1)) begin
            ps_next = ps_reg + PS_W'(1);
        end else begin
            ps_next    = '0;
            pfrac_next = pfrac_reg + 2'b01;
            if (pfrac_reg == 2'b11) begin
                pcnt_next = period_end ? 8'h00 : pcnt_reg + 8'h01;
            end
        end
        // duty latched at period start so a width change never glitches a pulse
        if (!pwm_on || period_end) begin
            dlat_next = {duty_reg, ctrl_reg[0][DUTY_LO_MSB:DUTY_LO_LSB]};
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ps_reg    <= '0;
            pfrac_reg <= 2'b00;
            pcnt_reg  <= 8'h00;
            dlat_reg  <= '0;
        end else if (ce_i) begin
            ps_reg    <= ps_next;
            pfrac_reg <= pfrac_next;
            pcnt_reg  <= pcnt_next;
            dlat_reg  <= dlat_next;
        end
    end

    // high while 10-bit position is below duty: width = tosc * duty * prescale
    assign mod = pwm_on && ({pcnt_reg, pfrac_reg} < dlat_reg);

    // half-bridge delayed pair
    logic half_a;
    logic half_b;
    ecp_dead_band #(.DLY_W(7)) u_db_a (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .ce_i     (ce_i),
        .in_i     (mod),
        .delay_i  (dead_reg[6:0]),
        .out_o    (half_a)
    );
    ecp_dead_band #(.DLY_W(7)) u_db_b (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .ce_i     (ce_i),
        .in_i     (pwm_on & ~mod),
        .delay_i  (dead_reg[6:0]),
        .out_o    (half_b)
    );

    // steering of the four outputs, registered
    ecp_bridge_s pins_reg;
    ecp_bridge_s pins_next;
    ecp_bridge_s oe_reg;
    ecp_bridge_s oe_next;

    always_comb begin
        pins_next = '0;
        oe_next   = '0;
        if (pwm_on) begin
            unique case (steer)
                ECP_STEER_SINGLE: begin
                    pins_next.a = mod;
                    oe_next.a   = 1'b1;
                end
                ECP_STEER_HALF: begin
                    pins_next.a = half_a;
                    pins_next.b = half_b;
                    oe_next     = '{a: 1'b1, b: 1'b1, c: 1'b0, d: 1'b0};
                end
                ECP_STEER_FWD: begin
                    pins_next = '{a: 1'b1, b: 1'b0, c: 1'b0, d: mod};
                    oe_next   = '1;
                end
                ECP_STEER_REV: begin
                    pins_next = '{a: 1'b0, b: mod, c: 1'b1, d: 1'b0};
                    oe_next   = '1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pins_reg <= '0;
            oe_reg   <= '0;
        end else if (ce_i) begin
            pins_reg <= pins_next;
            oe_reg   <= oe_next;
        end
    end

    // relocation: each pin goes either to its primary or to its alternate location
    logic [3:0] sel_alt;
    assign sel_alt = {reloc_reg[RELOC_A_BIT], reloc_reg[RELOC_B_BIT],
                      reloc_reg[RELOC_C_BIT], reloc_reg[RELOC_D_BIT]};
    // pin direction bits live in the port block; oe here only says the unit wants the pin
    assign bridge_pri_o    = pins_reg & ~sel_alt;
    assign bridge_alt_o    = pins_reg & sel_alt;
    assign bridge_oe_pri_o = oe_reg & ~sel_alt;
    assign bridge_oe_alt_o = oe_reg & sel_alt;
    assign capture_flag_o  = capf_reg;
endmodule

// ==== test/ecp_bridge_model.sv ====
// partner: external bridge switch stage on the primary bridge pins
`timescale 1ns/10ps
module ecp_bridge_model
    import ecp_pkg::*;
(
    input  wire logic        clk_i,
    input  wire ecp_bridge_s pin_i,
    input  wire ecp_bridge_s oe_i,
    output int               shoot_o
);
    ecp_bridge_s on;
    // a pin still set as input floats to the driver pull-down, switch off
    assign on = pin_i & oe_i;
    // both switches of one leg on shorts the supply; counted, never forgiven
    initial begin
        shoot_o = 0;
        forever @(posedge clk_i) begin
            if ((on.a & on.b) | (on.c & on.d)) shoot_o <= shoot_o + 1;
        end
    end
endmodule

// ==== test/ecp_checker.sv ====
// checker: port-level properties of the capture/pwm steering unit
`timescale 1ns/10ps
module ecp_checker
    import ecp_pkg::*;
#(
    parameter int PRESCALE = 1
) (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        ce_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pslverr_o,
    input wire ecp_bridge_s bridge_pri_o,
    input wire ecp_bridge_s bridge_oe_pri_o,
    input wire ecp_bridge_s bridge_oe_alt_o,
    input wire logic        capture_flag_o
);
    logic [7:0] ctl_reg, ctl_next;
    logic [3:0] rel_reg, rel_next, age_reg, age_next;
    logic       wr, bad, clr, ok, pwm;
    logic [6:0] dbd_reg, dbd_next;
    // shadow of unit1 control, relocation and dead band; age counts quiet cycles
    always_comb begin
        wr       = psel_i & penable_i & pwrite_i & ce_i;
        bad      = (paddr_i > OFS_CAPT_HIGH) | (paddr_i[1:0] != 2'b00);
        clr      = wr && paddr_i == OFS_CAPT_HIGH;
        ctl_next = (wr && paddr_i == OFS_UNIT1_CTRL) ? pwdata_i[7:0] : ctl_reg;
        rel_next = (wr && paddr_i == OFS_RELOC0) ? pwdata_i[3:0] : rel_reg;
        dbd_next = (wr && paddr_i == OFS_DEAD_BAND) ? pwdata_i[6:0] : dbd_reg;
        age_next = age_reg;
        if (wr) begin
            age_next = 4'h0;
        end else if (ce_i && age_reg != 4'hf) begin
            age_next = age_reg + 4'h1;
        end
        // pins lag a write by a register stage or two
        ok  = age_reg > 4'h3;
        pwm = ok && ctl_reg[3:2] == 2'b11;
    end
    // shadow follows the design's reset values
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl_reg <= 8'h00;
            dbd_reg <= 7'h00;
            rel_reg <= 4'h0;
            age_reg <= 4'h0;
        end else begin
            ctl_reg <= ctl_next;
            dbd_reg <= dbd_next;
            rel_reg <= rel_next;
            age_reg <= age_next;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    chk_fwd_idle: assert property (
        pwm && ctl_reg[7:6] == 2'b01 && rel_reg == 4'h0 |-> !bridge_pri_o.b && !bridge_pri_o.c)
        else $error("forward drives b or c");
    chk_rev_idle: assert property (
        pwm && ctl_reg[7:6] == 2'b11 && rel_reg == 4'h0 |-> !bridge_pri_o.a && !bridge_pri_o.d)
        else $error("reverse drives a or d");
    chk_full_oe: assert property (
        pwm && ctl_reg[6] && rel_reg == 4'h0 |-> bridge_oe_pri_o == 4'hf)
        else $error("full bridge enables");
    chk_half_overlap: assert property (
        pwm && ctl_reg[7:6] == 2'b10 |-> !(bridge_pri_o.a && bridge_pri_o.b))
        else $error("half bridge overlap");
    // a zero delay field gives no gap, so a may rise on the edge b falls
    chk_half_gap: assert property (
        pwm && ctl_reg[7:6] == 2'b10 && dbd_reg != 7'h00 && $fell(bridge_pri_o.b)
        |-> !bridge_pri_o.a)
        else $error("no dead band after b");
    chk_reloc_off: assert property (
        ok && rel_reg == 4'h0 |-> bridge_oe_alt_o == 4'h0)
        else $error("alternate pins driven");
    chk_unmapped_err: assert property (
        psel_i && penable_i && bad |-> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped access");
    chk_flag_clear: assert property (
        $fell(capture_flag_o) |-> $past(clr))
        else $error("capture flag lost");
endmodule
bind ecp_top ecp_checker #(.PRESCALE(PRESCALE)) i_ecp_checker (
    .clk_i, .resetn_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pslverr_o, .bridge_pri_o, .bridge_oe_pri_o, .bridge_oe_alt_o,
    .capture_flag_o);

// ==== test/ecp_top_tb_top.sv ====
// testbench: registers, pwm steering, dead band, timer and capture
`timescale 1ns/10ps
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, x); end end
module ecp_top_tb_top
    import ecp_pkg::*;
;
    logic        clk_i, resetn_i, ce_i, sleep_i, ext_clk_i, gate_i, capture_i;
    logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o, flag_o, ext_run, e;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i, prdata_o, r;
    ecp_bridge_s pri, alt, oe_pri, oe_alt;
    int          n_errors, compares, seed, shoot, w, d, k;
    ecp_steer_e  st [3] = '{ECP_STEER_SINGLE, ECP_STEER_FWD, ECP_STEER_REV};
    int          pk [3] = '{0, 3, 1};
    logic [7:0]  ofs [5] = '{OFS_UNIT1_CTRL, OFS_UNIT2_CTRL, OFS_DUTY_LOW, OFS_PERIOD,
                             OFS_TMR_CTRL};
    logic [7:0]  msk [5] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    logic [10:0] trow [6] = '{{8'h00, 3'b000}, {8'h01, 3'b001}, {8'h01, 3'b100},
                              {8'h01, 3'b001}, {8'h41, 3'b111}, {8'h41, 3'b000}};

    ecp_top #(.PRESCALE(1)) i_ecp_top (
        .clk_i, .resetn_i, .ce_i, .sleep_i, .ext_clk_i, .gate_i, .capture_i, .psel_i,
        .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .bridge_pri_o(pri), .bridge_alt_o(alt), .bridge_oe_pri_o(oe_pri),
        .bridge_oe_alt_o(oe_alt), .capture_flag_o(flag_o));
    ecp_bridge_model i_ecp_bridge_model (.clk_i, .pin_i(pri), .oe_i(oe_pri), .shoot_o(shoot));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // slow external timer clock, well inside the synchroniser's reach
    initial begin
        ext_clk_i = 1'b0;
        forever begin
            repeat (4) @(posedge clk_i);
            if (ext_run) ext_clk_i <= ~ext_clk_i;
        end
    end
    // one apb transfer; data read before the edge's register updates land
    task automatic apb(input logic wt, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wt;
        paddr_i   <= a;
        pwdata_i  <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, wd, rd, er);
    endtask
    task automatic rdv(input logic [7:0] a, output logic [31:0] rd);
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] rd;
        rdv(a, rd);
        `CHK(rd, x)
    endtask
    task automatic pwm_set(input ecp_steer_e s, input int dv);
        logic [9:0] q;
        q = dv[9:0];
        wr(OFS_DUTY_LOW, {24'h0, q[9:2]});
        wr(OFS_UNIT1_CTRL, {24'h0, s, q[1:0], MODE_PWM_MSB});
    endtask
    // high time of one pin in clocks, sampled on falling edges
    task automatic meas(input int i, output int n);
        int t;
        t = 0;
        n = 0;
        for (int s = 0; s < 3; s++) begin
            while (pri[3 - i] !== (s == 1) && t < 999) begin
                @(negedge clk_i);
                t++;
                n += (s == 2);
            end
        end
        if (t >= 999) n_errors++;
    endtask
    // did the timer low byte move over some twenty clocks
    task automatic tdelta(output logic ch);
        logic [31:0] a0, a1;
        // let synchronised pin edges and sleep changes settle before the first read
        repeat (6) @(posedge clk_i);
        rdv(OFS_TMR_LOW, a0);
        repeat (20) @(posedge clk_i);
        rdv(OFS_TMR_LOW, a1);
        ch = (a0 !== a1);
    endtask
    task automatic summarize();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // the whole run needs well under ten thousand clocks
    initial begin
        repeat (40000) @(posedge clk_i);
        n_errors++;
        summarize();
    end
    initial begin
        seed = 32'h04fdd2ab;
        {resetn_i, ce_i, sleep_i, gate_i, capture_i, ext_run} = 6'b010000;
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        n_errors = 0;
        compares = 0;
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        // reset values, random read back, unimplemented bits, refused accesses
        chk_rd(OFS_UNIT1_CTRL, {24'h0, CTRL_RST});
        chk_rd(OFS_PERIOD, {24'h0, PERIOD_RST});
        chk_rd(OFS_RELOC0, 32'h0);
        for (int i = 0; i < 5; i++) begin
            d = $random(seed);
            wr(ofs[i], d);
            chk_rd(ofs[i], {24'h0, d[7:0] & msk[i]});
        end
        wr(OFS_UNIT3_CTRL, 32'hff);
        chk_rd(OFS_UNIT3_CTRL, 32'h3f);
        wr(OFS_UNIT4_CTRL, 32'hc5);
        chk_rd(OFS_UNIT4_CTRL, 32'h05);
        apb(1'b0, 8'h40, 32'h0, r, e);
        `CHK({e, r}, 33'h100000000)
        ce_i <= 1'b0;
        wr(OFS_DEAD_BAND, 32'h55);
        ce_i <= 1'b1;
        chk_rd(OFS_DEAD_BAND, {24'h0, DATA_RST});
        $display("test regs done");
        // widths of the modulated pin per steering mode, static pins
        // pwm off first, so the counter restarts inside the shorter period
        wr(OFS_UNIT1_CTRL, 32'h0);
        wr(OFS_PERIOD, 32'h0f);
        for (int i = 0; i < 3; i++) begin
            d = 4 + {$random(seed)} % 56;
            pwm_set(st[i], d);
            meas(pk[i], w);
            meas(pk[i], w);
            `CHK(w, d)
            if (i == 1) `CHK({pri.a, pri.b, pri.c, oe_pri}, 7'h4f)
            if (i == 2) `CHK({pri.a, pri.c, pri.d, oe_pri}, 7'h2f)
        end
        wr(OFS_RELOC0, 32'hf);
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        `CHK({alt.c, oe_alt, oe_pri}, 9'h1f0)
        wr(OFS_RELOC0, 32'h0);
        // half bridge: both widths shortened by the dead band
        k = {$random(seed)} % 4;
        wr(OFS_DEAD_BAND, k);
        pwm_set(ECP_STEER_HALF, 40);
        meas(0, w);
        meas(0, w);
        `CHK(w, 40 - 4 * k)
        meas(1, w);
        `CHK(w, 24 - 4 * k)
        `CHK(shoot, 0)
        $display("test pwm done");
        // timer: off, tick, sleep hold, resume, external clock asleep and idle
        foreach (trow[i]) begin
            wr(OFS_TMR_CTRL, {24'h0, trow[i][10:3]});
            sleep_i <= trow[i][2];
            ext_run <= trow[i][1];
            tdelta(e);
            `CHK(e, trow[i][0])
        end
        // gate enable lives in the gate register, polarity left at true-high
        wr(OFS_TMR_CTRL, 32'h01);
        wr(OFS_TMR_GATE, 32'h80);
        gate_i <= 1'b0;
        tdelta(e);
        gate_i <= 1'b1;
        tdelta(r[0]);
        `CHK({e, r[0]}, 2'b01)
        $display("test timer done");
        // capture edge taken asleep on the external clock, then cleared
        wr(OFS_UNIT1_CTRL, {28'h0, MODE_CAPTURE});
        wr(OFS_TMR_CTRL, 32'h41);
        sleep_i <= 1'b1;
        ext_run <= 1'b1;
        repeat (8) @(posedge clk_i);
        capture_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk_rd(OFS_RELOC1, 32'h1);
        `CHK(flag_o, 1'b1)
        wr(OFS_CAPT_HIGH, 32'h0);
        chk_rd(OFS_RELOC1, 32'h0);
        `CHK(flag_o, 1'b0)
        $display("test capture done");
        summarize();
    end
endmodule
